// File: cmc_map.svh
// Register map, field positions and reset values of the mailbox control block
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH
`define CMC_SLOTS        16
`define CMC_IDX_MOD0     12'h200
`define CMC_IDX_MOD1     12'h220
`define CMC_IDX_CTL      12'h240
`define CMC_B_STAT0      0
`define CMC_B_STAT1      1
`define CMC_B_LOST       2
`define CMC_B_REMPH      3
`define CMC_B_LOCK       4
`define CMC_B_REMOTE     5
`define CMC_B_RXSEL      6
`define CMC_B_TXSEL      7
`define CMC_CTL_LOOP0    0
`define CMC_CTL_DUAL0    1
`define CMC_CTL_LOOP1    2
`define CMC_CTL_DUAL1    3
`define CMC_RESP_OKAY    2'h0
`define CMC_RESP_SLVERR  2'h2
`define CMC_RST_BYTE     8'h00
`endif

// File: cmc_pkg.sv
// Types of the mailbox control block
`include "cmc_map.svh"
package cmc_pkg;
    typedef logic [4:0] cmc_id_t;
    typedef enum logic {CMC_IDLE, CMC_WRITE} cmc_fsm_e;
    typedef struct packed {
        logic tx, rx, rem, lock;
        logic s3, s2, s1, s0;
        logic armed;
    } cmc_slot_s;
    typedef struct packed {
        cmc_slot_s [31:0] slot;
        logic [1:0]  alt;
        logic [3:0]  ctl;
        cmc_fsm_e    fsm;
        cmc_id_t     wr_slot;
        logic        wr_remote;
        logic        tx_busy;
        logic        aw_have, w_have;
        logic [31:0] aw_addr, w_data;
        logic [3:0]  w_strb;
        logic        bvalid, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        txr_valid, txr_remote;
        cmc_id_t     txr_slot;
    } cmc_state_s;
endpackage

// File: cmc_mailbox_ctrl.sv
// Message slot control for two modules of sixteen CAN mailboxes, AXI4-Lite slave
//
// Contract
// - Storing a new message into a receive slot sets its fresh flag.
// - Error-free transmission of a transmit slot sets its done flag.
// - Update-pending flag is high while slot content is being written.
// - In-progress flag is high only while the frame is really sent.
// - Overwriting an unread message in a receive slot sets the overrun flag.
// - Remote-phase flag marks active remote step; dual slots mark stored remote frames.
// - Auto-reply block set stops the automatic answer to a remote frame.
// - CPU writes may only clear the status flags; writing one keeps them.
// - Both selects zero means inactive; only then a new mode is accepted.
// - Mode rx-only without remote receives data frames.
// - Mode tx-only without remote transmits data frames.
// - Remote request mode sends remote frame, then becomes data receiver.
// - Matching data frame before the request is sent makes it receiver at once.
// - Remote receive mode takes a remote frame, then becomes data transmitter.
// - A frame is stored once, in the lowest matching slot.
// - Own transmitted frames are not stored in normal operation.
// - In loop-back mode own frames are stored in a matching receive slot.
// - After an abort, done flag tells whether the frame still went out.
// - Dual-slot mode stores frames alternately in the two top slots.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.svh"
module cmc_mailbox_ctrl #(
    parameter int SLOTS = `CMC_SLOTS
) (
    input  wire logic           sys_clk,
    input  wire logic           rst,
    input  wire logic [31:0]    s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output var  logic           s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output var  logic           s_axi_wready,
    output var  logic [1:0]     s_axi_bresp,
    output var  logic           s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire logic [31:0]    s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output var  logic           s_axi_arready,
    output var  logic [31:0]    s_axi_rdata,
    output var  logic [1:0]     s_axi_rresp,
    output var  logic           s_axi_rvalid,
    input  wire logic           s_axi_rready,
    output var  logic           tx_req_valid,
    output var  cmc_pkg::cmc_id_t tx_req_slot,
    output var  logic           tx_req_remote,
    input  wire logic           eng_tx_start,
    input  wire logic           eng_tx_end,
    input  wire logic           eng_tx_ok,
    input  wire logic           eng_rx_valid,
    input  wire logic           eng_rx_mod,
    input  wire logic [15:0]    eng_rx_match,
    input  wire logic           eng_rx_remote,
    input  wire logic           eng_rx_own,
    output var  logic           eng_rx_ready,
    output var  logic           rx_wr_valid,
    output var  cmc_pkg::cmc_id_t rx_wr_slot,
    input  wire logic           eng_wr_done
);
    import cmc_pkg::*;

    // The slot id carries the module in bit 4, so one module is capped at 16 slots
    initial begin
        if (SLOTS < 2 || SLOTS > `CMC_SLOTS) begin
            $error("SLOTS must lie between 2 and 16");
        end
    end

    cmc_state_s q, d;

    // Lowest set bit: {found, index}
    function automatic logic [4:0] cmc_first(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 15; k >= 0; k--) begin
            if (v[k]) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction

    // Address decode: {hit, is_ctl, module, slot}
    function automatic logic [6:0] cmc_dec(input logic [31:0] a);
        logic [11:0] idx;
        logic [6:0]  r;
        idx = a[13:2];
        r = 7'h00;
        if (a[31:14] == 18'h00000) begin
            if (idx == `CMC_IDX_CTL) begin
                r = 7'h60;
            end else if (idx >= `CMC_IDX_MOD0 && idx < `CMC_IDX_MOD0 + 12'(SLOTS)) begin
                r = {3'b100, idx[3:0]};
            end else if (idx >= `CMC_IDX_MOD1 && idx < `CMC_IDX_MOD1 + 12'(SLOTS)) begin
                r = {3'b101, idx[3:0]};
            end
        end
        return r;
    endfunction

    // Next-state logic: bus first, engine events afterwards so a set wins over a clear
    always_comb begin
        logic [6:0]  dec;
        logic [7:0]  wb;
        logic [15:0] elig;
        logic [15:0] armv;
        logic [4:0]  pick;
        logic [4:0]  txp;
        logic        dual, loopb, was_cfg;
        cmc_id_t     sid;
        dec = 7'h00;
        wb = 8'h00;
        elig = 16'h0000;
        armv = 16'h0000;
        pick = 5'h00;
        txp = 5'h00;
        dual = 1'b0;
        loopb = 1'b0;
        was_cfg = 1'b0;
        sid = 5'h00;
        d = q;

        // Write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            dec = cmc_dec(q.aw_addr);
            wb = q.w_data[7:0];
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = dec[6] ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
            if (dec[6] && q.w_strb[0]) begin
                if (dec[5]) begin
                    d.ctl = wb[3:0];
                end else begin
                    sid = dec[4:0];
                    was_cfg = !q.slot[sid].tx && !q.slot[sid].rx;
                    d.slot[sid].s0 = q.slot[sid].s0 & wb[`CMC_B_STAT0];
                    d.slot[sid].s2 = q.slot[sid].s2 & wb[`CMC_B_LOST];
                    d.slot[sid].s3 = q.slot[sid].s3 & wb[`CMC_B_REMPH];
                    // in-progress is engine owned in transmit mode
                    if (!q.slot[sid].tx) begin
                        d.slot[sid].s1 = q.slot[sid].s1 & wb[`CMC_B_STAT1];
                    end
                    d.slot[sid].lock = wb[`CMC_B_LOCK];
                    // mode only changes from or into configuration
                    if (was_cfg || !(wb[`CMC_B_TXSEL] | wb[`CMC_B_RXSEL])) begin
                        d.slot[sid].tx = wb[`CMC_B_TXSEL];
                        d.slot[sid].rx = wb[`CMC_B_RXSEL];
                        d.slot[sid].rem = wb[`CMC_B_REMOTE];
                        // clearing both selects withdraws a pending request
                        d.slot[sid].armed = wb[`CMC_B_TXSEL];
                        if (wb[`CMC_B_REMOTE] && (wb[`CMC_B_TXSEL] ^ wb[`CMC_B_RXSEL])) begin
                            d.slot[sid].s3 = 1'b1;
                        end
                    end
                end
            end
        end

        // Read channel: one read under way, answered one cycle after it is taken
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            dec = cmc_dec(s_axi_araddr);
            d.rvalid = 1'b1;
            d.rresp = dec[6] ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR;
            d.rdata = 32'h00000000;
            if (dec[6] && dec[5]) begin
                d.rdata[3:0] = q.ctl;
            end else if (dec[6]) begin
                // Slot fields tx down to s0 sit in byte order above the armed bit
                d.rdata[7:0] = q.slot[dec[4:0]][8:1];
            end
        end

        // in progress only from the engine's start to its end
        if (eng_tx_start && q.txr_valid) begin
            d.slot[q.txr_slot].s1 = 1'b1;
            d.tx_busy = 1'b1;
        end
        if (eng_tx_end && q.tx_busy) begin
            d.tx_busy = 1'b0;
            d.slot[q.txr_slot].s1 = 1'b0;
            if (eng_tx_ok) begin
                // done set even when the slot was aborted meanwhile
                d.slot[q.txr_slot].s0 = 1'b1;
                d.slot[q.txr_slot].armed = 1'b0;
                // remote request sent, slot turns into a data receiver
                if (q.slot[q.txr_slot].tx && q.slot[q.txr_slot].rem) begin
                    d.slot[q.txr_slot].tx = 1'b0;
                    d.slot[q.txr_slot].rx = 1'b1;
                    d.slot[q.txr_slot].rem = 1'b0;
                    d.slot[q.txr_slot].s3 = 1'b0;
                end
            end
        end

        // Receive slot choice for the frame just offered
        dual = eng_rx_mod ? q.ctl[`CMC_CTL_DUAL1] : q.ctl[`CMC_CTL_DUAL0];
        loopb = eng_rx_mod ? q.ctl[`CMC_CTL_LOOP1] : q.ctl[`CMC_CTL_LOOP0];
        for (int k = 0; k < SLOTS; k++) begin
            cmc_slot_s s;
            s = q.slot[{eng_rx_mod, 4'(k)}];
            if (dual && k >= SLOTS - 2) begin
                // dual slots take both frame kinds
                elig[k] = s.rx && !s.tx;
            end else if (eng_rx_remote) begin
                // only remote receive slots take remote frames
                elig[k] = !s.tx && s.rx && s.rem;
            end else begin
                // data receivers and still unsent remote requests
                elig[k] = (!s.tx && s.rx && !s.rem) || (s.tx && !s.rx && s.rem && !s.s1);
            end
        end
        elig = elig & eng_rx_match;
        if (dual) begin
            elig[SLOTS-1] = 1'b0;
            // alternate between the two top slots
            elig[SLOTS-2] = q.alt[eng_rx_mod] ? 1'b0 : elig[SLOTS-2];
            if (q.alt[eng_rx_mod] && (eng_rx_match[SLOTS-1] & q.slot[{eng_rx_mod, 4'(SLOTS-1)}].rx)
                    && (elig[SLOTS-3:0] == '0)) begin
                elig[SLOTS-1] = 1'b1;
            end
        end
        // lowest slot wins, stored only once
        pick = cmc_first(elig);
        sid = {eng_rx_mod, pick[3:0]};

        // own frames only reach a slot in loop-back
        if (q.fsm == CMC_IDLE && eng_rx_valid && pick[4] && (!eng_rx_own || loopb)) begin
            d.fsm = CMC_WRITE;
            d.wr_slot = sid;
            d.wr_remote = eng_rx_remote;
            d.slot[sid].s1 = 1'b1;
            if (dual && pick[3:0] >= 4'(SLOTS - 2)) begin
                d.alt[eng_rx_mod] = ~q.alt[eng_rx_mod];
            end
            // data frame seen first: drop the request, become receiver
            if (q.slot[sid].tx) begin
                d.slot[sid].tx = 1'b0;
                d.slot[sid].rx = 1'b1;
                d.slot[sid].rem = 1'b0;
                d.slot[sid].s3 = 1'b0;
                d.slot[sid].armed = 1'b0;
            end
        end
        if (q.fsm == CMC_WRITE && eng_wr_done) begin
            d.fsm = CMC_IDLE;
            d.slot[q.wr_slot].s1 = 1'b0;
            if (q.slot[q.wr_slot].s0) begin
                d.slot[q.wr_slot].s2 = 1'b1;
            end
            d.slot[q.wr_slot].s0 = 1'b1;
            dual = q.wr_slot[4] ? q.ctl[`CMC_CTL_DUAL1] : q.ctl[`CMC_CTL_DUAL0];
            if (dual && q.wr_slot[3:0] >= 4'(SLOTS - 2)) begin
                // frame kind of the last stored frame
                d.slot[q.wr_slot].s3 = q.wr_remote;
            end else if (q.slot[q.wr_slot].rem && q.slot[q.wr_slot].rx) begin
                // remote frame taken, become data transmitter
                d.slot[q.wr_slot].tx = 1'b1;
                d.slot[q.wr_slot].rx = 1'b0;
                d.slot[q.wr_slot].rem = 1'b0;
                d.slot[q.wr_slot].s3 = 1'b0;
                d.slot[q.wr_slot].s0 = 1'b0;
                d.slot[q.wr_slot].armed = 1'b1;
            end
        end

        // Transmit offer: lowest armed slot, module 0 before module 1
        for (int m = 1; m >= 0; m--) begin
            for (int k = 0; k < SLOTS; k++) begin
                cmc_slot_s s;
                s = d.slot[{m[0], 4'(k)}];
                armv[k] = s.armed && s.tx && !s.rx && !s.lock;
            end
            txp = cmc_first(armv);
            if (txp[4] && !d.tx_busy) begin
                d.txr_slot = {m[0], txp[3:0]};
                d.txr_remote = d.slot[{m[0], txp[3:0]}].rem;
            end
        end
        if (!d.tx_busy) begin
            d.txr_valid = 1'b0;
            for (int m = 0; m < 2; m++) begin
                for (int k = 0; k < SLOTS; k++) begin
                    if (d.slot[{m[0], 4'(k)}].armed && d.slot[{m[0], 4'(k)}].tx
                            && !d.slot[{m[0], 4'(k)}].rx && !d.slot[{m[0], 4'(k)}].lock) begin
                        d.txr_valid = 1'b1;
                    end
                end
            end
        end else begin
            d.txr_valid = 1'b0;
        end
    end

    // All state in one register; reset gives every slot configuration mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register; readies are decoded from state bits only
    always_comb begin
        s_axi_awready = !q.aw_have && !q.bvalid;
        s_axi_wready = !q.w_have && !q.bvalid;
        s_axi_bvalid = q.bvalid;
        s_axi_bresp = q.bresp;
        s_axi_arready = !q.rvalid;
        s_axi_rvalid = q.rvalid;
        s_axi_rdata = q.rdata;
        s_axi_rresp = q.rresp;
        tx_req_valid = q.txr_valid;
        tx_req_slot = q.txr_slot;
        tx_req_remote = q.txr_remote;
        eng_rx_ready = q.fsm == CMC_IDLE;
        rx_wr_valid = q.fsm == CMC_WRITE;
        rx_wr_slot = q.wr_slot;
    end
endmodule
`default_nettype wire

// File: cmc_mailbox_ctrl_sva.sv
// Assertion checker for the mailbox control block ports
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.svh"
module cmc_mailbox_ctrl_sva (
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic [31:0]      s_axi_araddr,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic             tx_req_valid,
    input wire logic             eng_tx_start,
    input wire logic             eng_tx_end,
    input wire logic             rx_wr_valid,
    input wire cmc_pkg::cmc_id_t rx_wr_slot,
    input wire logic             eng_wr_done
);
    import cmc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Mapped: two slot banks and the control word
    function automatic logic mapped(input logic [31:0] a);
        return a[31:12] == 20'h0 && a[1:0] == 2'h0 &&
            (a[11:6] == 6'h20 || a[11:6] == 6'h22 || a[11:2] == 10'h240);
    endfunction
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp ==
            (mapped($past(s_axi_araddr)) ? `CMC_RESP_OKAY : `CMC_RESP_SLVERR);
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response wrong");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer not held");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during answer");
    property p_rd_width;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
    property p_b_follow;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##[0:1] s_axi_bvalid;
    endproperty
    a_b_follow: assert property (p_b_follow) else $error("write answer late");
    property p_tx_drop;
        eng_tx_start && tx_req_valid |=> (!tx_req_valid) [*2];
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("request kept while sending");
    property p_tx_gap;
        eng_tx_end |=> !tx_req_valid;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("request right after frame end");
    property p_wr_hold;
        rx_wr_valid && !eng_wr_done |=> rx_wr_valid && $stable(rx_wr_slot);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("slot write not held");
    property p_wr_end;
        rx_wr_valid && eng_wr_done |=> !rx_wr_valid;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("slot write not closed");
endmodule
// Every checker port has the name of the design port it watches
bind cmc_mailbox_ctrl cmc_mailbox_ctrl_sva u_cmc_mailbox_ctrl_sva (.*);
`default_nettype wire

// File: cmc_engine_model.sv
// Behavioural CAN protocol engine facing the mailbox control block
`timescale 1ns/1ps
`default_nettype none
module cmc_engine_model (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   tx_req_valid,
    input  wire logic   eng_rx_ready,
    input  wire logic   rx_wr_valid,
    input  wire logic   hold,
    output logic        eng_tx_start,
    output logic        eng_tx_end,
    output logic        eng_tx_ok,
    output logic        eng_rx_valid,
    output logic        eng_rx_mod,
    output logic [15:0] eng_rx_match,
    output logic        eng_rx_remote,
    output logic        eng_rx_own,
    output logic        eng_wr_done
);
    int cnt;
    int wlat;
    initial begin
        {eng_rx_valid, eng_rx_mod, eng_rx_remote, eng_rx_own} = 4'h0;
        eng_rx_match = 16'h0;
    end
    // Sending: hold models a busy bus; two quiet cycles follow every frame end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {eng_tx_start, eng_tx_end, eng_tx_ok} <= 3'h0;
            cnt <= 0;
        end else begin
            eng_tx_start <= 1'b0;
            eng_tx_end <= 1'b0;
            eng_tx_ok <= ~eng_tx_ok; // Meaningless outside the end pulse
            if (cnt != 0) begin
                cnt <= cnt - 1;
            end else if (tx_req_valid && !hold) begin
                eng_tx_start <= 1'b1;
                cnt <= 14;
            end
            if (cnt == 3) begin
                eng_tx_end <= 1'b1;
                eng_tx_ok <= 1'b1;
            end
        end
    end
    // Slot writes are acknowledged a few cycles late, one pulse per write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eng_wr_done <= 1'b0;
            wlat <= 0;
        end else begin
            eng_wr_done <= 1'b0;
            if (!rx_wr_valid || eng_wr_done) wlat <= 0;
            else if (wlat == 4) eng_wr_done <= 1'b1;
            else wlat <= wlat + 1;
        end
    end
    // One received frame; qualifiers are scrambled once the pulse is over
    task automatic send(input logic m, input logic [15:0] mt, input logic rm, input logic ow);
        while (!eng_rx_ready) @(posedge sys_clk);
        eng_rx_valid <= 1'b1;
        eng_rx_mod <= m;
        eng_rx_match <= mt;
        eng_rx_remote <= rm;
        eng_rx_own <= ow;
        @(posedge sys_clk);
        eng_rx_valid <= 1'b0;
        eng_rx_match <= ~mt;
        {eng_rx_mod, eng_rx_remote, eng_rx_own} <= ~{m, rm, ow};
    endtask
endmodule
`default_nettype wire

// File: cmc_mailbox_ctrl_bench.sv
// Self-checking bench for the mailbox control block
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.svh"
module cmc_mailbox_ctrl_bench;
    import cmc_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1, hold = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        tx_req_valid, tx_req_remote, eng_tx_start, eng_tx_end, eng_tx_ok;
    logic        eng_rx_valid, eng_rx_mod, eng_rx_remote, eng_rx_own, eng_rx_ready;
    logic        rx_wr_valid, eng_wr_done;
    logic [15:0] eng_rx_match;
    cmc_id_t     tx_req_slot, rx_wr_slot;
    int          miscompares = 0, check_count = 0, cyc = 0, starts = 0, n;
    cmc_mailbox_ctrl u_cmc_mailbox_ctrl (.*);
    cmc_engine_model u_cmc_engine_model (.*);
    always #5 sys_clk = ~sys_clk;
    // Hang guard and frame-start count
    always @(posedge sys_clk) begin
        cyc++;
        if (eng_tx_start) starts++;
        if (cyc == 5000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t data %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t resp %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] sa(input int m, input int i);
        return 32'h800 + 32'(m) * 32'h80 + 32'(i) * 32'h4;
    endfunction
    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk_r(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask
    task automatic rc(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(rd_d[7:0] & m, e);
        chk_r(rd_r, `CMC_RESP_OKAY);
    endtask
    // A frame, then wait until its slot write (if any) is closed
    task automatic fr(input logic m, input logic [15:0] mt, input logic rm, input logic ow);
        u_cmc_engine_model.send(m, mt, rm, ow);
        @(posedge sys_clk);
        while (rx_wr_valid) @(posedge sys_clk);
    endtask
    task automatic ev(ref logic s);
        @(posedge sys_clk);
        while (!s) @(posedge sys_clk);
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rc(sa(0, 0), 8'hff, 8'h00);
        rc(sa(1, 15), 8'hff, 8'h00);
        rd(32'h904);
        chk_r(rd_r, `CMC_RESP_SLVERR);
        chk(rd_d[7:0], 8'h00);
        wr(32'h904, 8'h40, `CMC_RESP_SLVERR);
        wr(sa(0, 9), 8'h0f, `CMC_RESP_OKAY);
        rc(sa(0, 9), 8'hff, 8'h00);
        // Receive, overrun and write-one-keeps behaviour
        wr(sa(0, 0), 8'h40, `CMC_RESP_OKAY);
        wr(sa(0, 1), 8'h40, `CMC_RESP_OKAY);
        fr(1'b0, 16'h0003, 1'b0, 1'b0);
        rc(sa(0, 0), 8'hff, 8'h41);
        rc(sa(0, 1), 8'hff, 8'h40);
        wr(sa(0, 0), 8'h47, `CMC_RESP_OKAY);
        rc(sa(0, 0), 8'hff, 8'h41);
        fr(1'b0, 16'h0001, 1'b0, 1'b0);
        rc(sa(0, 0), 8'hff, 8'h45);
        wr(sa(0, 0), 8'h40, `CMC_RESP_OKAY);
        rc(sa(0, 0), 8'hff, 8'h40);
        fr(1'b0, 16'h0001, 1'b0, 1'b1);
        rc(sa(0, 0), 8'hff, 8'h40);
        wr(32'h900, 8'h01, `CMC_RESP_OKAY);
        fr(1'b0, 16'h0001, 1'b0, 1'b1);
        rc(sa(0, 0), 8'hff, 8'h41);
        wr(32'h900, 8'h00, `CMC_RESP_OKAY);
        // Plain data transmission
        wr(sa(0, 2), 8'h80, `CMC_RESP_OKAY);
        ev(eng_tx_start);
        rc(sa(0, 2), 8'hff, 8'h82);
        ev(eng_tx_end);
        rc(sa(0, 2), 8'hff, 8'h81);
        // Remote request: waits on a busy bus, then sends and turns receiver
        hold <= 1'b1;
        wr(sa(0, 3), 8'ha0, `CMC_RESP_OKAY);
        rc(sa(0, 3), 8'hff, 8'ha8);
        hold <= 1'b0;
        ev(eng_tx_start);
        chk({7'h0, tx_req_remote}, 8'h01);
        chk({3'h0, tx_req_slot}, 8'h03);
        ev(eng_tx_end);
        rc(sa(0, 3), 8'hf8, 8'h40);
        hold <= 1'b1;
        wr(sa(0, 4), 8'ha0, `CMC_RESP_OKAY);
        fr(1'b0, 16'h0010, 1'b0, 1'b0);
        hold <= 1'b0;
        rc(sa(0, 4), 8'hf8, 8'h40);
        // Remote receive with and without the automatic answer
        wr(sa(0, 5), 8'h60, `CMC_RESP_OKAY);
        rc(sa(0, 5), 8'hf8, 8'h68);
        fr(1'b0, 16'h0020, 1'b1, 1'b0);
        ev(eng_tx_end);
        rc(sa(0, 5), 8'hfb, 8'h81);
        n = starts;
        wr(sa(0, 6), 8'h70, `CMC_RESP_OKAY);
        fr(1'b0, 16'h0040, 1'b1, 1'b0);
        repeat (30) @(posedge sys_clk);
        chk(8'(starts - n), 8'h00);
        rc(sa(0, 6), 8'hf8, 8'h90);
        // Abort before sending, then abort too late
        hold <= 1'b1;
        wr(sa(0, 7), 8'h80, `CMC_RESP_OKAY);
        wr(sa(0, 7), 8'h00, `CMC_RESP_OKAY);
        rc(sa(0, 7), 8'hff, 8'h00);
        hold <= 1'b0;
        wr(sa(0, 8), 8'h80, `CMC_RESP_OKAY);
        ev(eng_tx_start);
        wr(sa(0, 8), 8'h00, `CMC_RESP_OKAY);
        do rd(sa(0, 8)); while (rd_d[1] !== 1'b0);
        chk(rd_d[7:0], 8'h01);
        // Dual-slot channel on the second module
        wr(32'h900, 8'h08, `CMC_RESP_OKAY);
        wr(sa(1, 14), 8'h40, `CMC_RESP_OKAY);
        wr(sa(1, 15), 8'h40, `CMC_RESP_OKAY);
        fr(1'b1, 16'hc000, 1'b0, 1'b0);
        fr(1'b1, 16'hc000, 1'b1, 1'b0);
        rc(sa(1, 14), 8'hff, 8'h41);
        rc(sa(1, 15), 8'hff, 8'h49);
        end_sim();
    end
endmodule
`default_nettype wire
